// ===== hdl/uart_pkg.sv
// Constants, register map and state types for the serial port
package uart_pkg;
    // Register byte offsets
    localparam logic [7:0] CTL_OFS   = 8'h00;
    localparam logic [7:0] BUF_OFS   = 8'h04;
    localparam logic [7:0] PWR_OFS   = 8'h08;
    localparam logic [7:0] ADDR_OFS  = 8'h0C;
    localparam logic [7:0] MASK_OFS  = 8'h10;
    localparam logic [7:0] BAUD_OFS  = 8'h14;
    localparam logic [7:0] ISTAT_OFS = 8'h18;
    localparam logic [7:0] IMASK_OFS = 8'h1C;
    // Serial control register fields
    localparam int CTL_RX_DONE     = 0;
    localparam int CTL_TX_DONE     = 1;
    localparam int CTL_RX_B9       = 2;
    localparam int CTL_TX_B9       = 3;
    localparam int CTL_RX_ALLOW    = 4;
    localparam int CTL_FILTER      = 5;
    localparam int CTL_MODE_B      = 6;
    localparam int CTL_MODE_A      = 7;
    localparam int CTL_FRAME_FAULT = 8;
    localparam int CTL_W           = 9;
    // Power control register field
    localparam int PWR_FRAME_CHECK = 6;
    // Interrupt status and mask fields
    localparam int IRQ_TX    = 0;
    localparam int IRQ_RX    = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_W     = 3;
    // Reset values
    localparam logic [CTL_W-1:0] CTL_RST  = 9'h000;
    localparam logic [7:0]       ADDR_RST = 8'h00;
    localparam logic [7:0]       MASK_RST = 8'h00;
    localparam logic [15:0]      BAUD_RST = 16'h01B2;
    // Bit times in clock cycles
    localparam logic [15:0] M0_BIT_CYC = 16'h000C;
    localparam logic [15:0] M2_BIT_CYC = 16'h0040;

    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_8VAR  = 2'b01,
        MODE_9FIX  = 2'b10,
        MODE_9VAR  = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_RUN  = 2'b10
    } tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_t;
endpackage

// ===== hdl/uart_frame_check_addr_match.sv
// Full-duplex serial port with stop-bit checking and address filtering
//
// Operation
// [RULE1] One buffer location: write loads transmitter, read returns receiver.
// [RULE2] Two mode-select bits of the control register pick one of four modes.
// [RULE3] Any buffer write starts a transmission in every mode.
// [RULE4] Mode 0 reception starts when receive-done is clear and receive-allow set.
// [RULE5] Other modes receive on a start bit only while receive-allow is set.
// [RULE6] Stop-bit check in modes 1-3, enabled by the frame-check select bit.
// [RULE7] Checked frame without valid stop bit sets the framing-fault flag.
// [RULE8] Framing-fault flag stays set until software clears it.
// [RULE9] With checking on, receive-done rises at the stop bit.
// [RULE10] Filter on, 9-bit modes: only matching address frames set receive-done.
// [RULE11] Filter off: data frames with ninth bit 0 are accepted normally.
// [RULE12] Ninth bit 1 marks address frames, 0 marks data frames.
// [RULE13] Mode 1 with filter: stop bit is ninth bit, must be valid.
// [RULE14] Mode 0 ignores the filter bit.
// [RULE15] Given address: mask 0 is don't-care, mask 1 must equal own address.
// [RULE16] Broadcast is own address OR mask, zeros don't-care.
// [RULE17] Reset clears own address and mask so every address matches.
// [RULE18] Modes: 0 shift register, 1 8-bit var, 2 9-bit fixed, 3 9-bit var.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module uart_frame_check_addr_match (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        RXD_I,
    output var  logic        RXD_O,
    output var  logic        RXD_OE_N,
    output var  logic        TXD,
    output var  logic        IRQ
);

    typedef struct packed {
        logic [uart_pkg::CTL_W-1:0] ctl;
        logic                       fc_sel;
        logic [7:0]                 own_addr;
        logic [7:0]                 mask;
        logic [15:0]                baud;
        logic [7:0]                 rx_buf;
        logic [uart_pkg::IRQ_W-1:0] istat;
        logic [uart_pkg::IRQ_W-1:0] imask;
        uart_pkg::tx_state_t        tx_st;
        logic [10:0]                tx_sh;
        logic [3:0]                 tx_bits;
        logic [15:0]                tx_cnt;
        logic                       m0_rx;
        uart_pkg::rx_state_t        rx_st;
        logic [15:0]                rx_cnt;
        logic [3:0]                 rx_bits;
        logic [8:0]                 rx_sh;
        logic                       rxd_prev;
        logic                       txd;
        logic                       rxd_o;
        logic                       rxd_oe_n;
        logic                       pready;
        logic [31:0]                prdata;
        logic                       pslverr;
        logic                       irq;
    } state_t;

    state_t q;
    state_t n;

    uart_pkg::mode_t            mode;
    logic [15:0]                bit_len;
    logic [15:0]                half_len;
    logic [uart_pkg::IRQ_W-1:0] ev;
    logic                       filt;
    logic                       early;
    logic                       dec_now;
    logic                       dec_b9;
    logic [7:0]                 dec_data;
    logic                       match;
    logic [7:0]                 bcast;
    logic                       mapped;
    logic                       commit;
    logic [31:0]                rd;

    always_comb begin
        n        = q;
        ev       = '0;
        dec_now  = 1'b0;
        dec_b9   = 1'b0;
        dec_data = 8'h00;
        // **************************************************
        // Mode decode and bit timing
        // **************************************************
        // [RULE2] mode from select bits
        mode = uart_pkg::mode_t'({q.ctl[uart_pkg::CTL_MODE_A], q.ctl[uart_pkg::CTL_MODE_B]});
        // [RULE18] rate per mode
        unique case (mode)
            uart_pkg::MODE_SHIFT: bit_len = uart_pkg::M0_BIT_CYC;
            uart_pkg::MODE_9FIX:  bit_len = uart_pkg::M2_BIT_CYC;
            default:              bit_len = q.baud;
        endcase
        half_len = {1'b0, bit_len[15:1]};
        // [RULE14] filter ignored in mode 0
        filt  = q.ctl[uart_pkg::CTL_FILTER] && (mode != uart_pkg::MODE_SHIFT);
        // [RULE9] early decision only without stop check
        early = !q.fc_sel && !(mode == uart_pkg::MODE_8VAR && filt);

        // **************************************************
        // APB slave, one wait state
        // **************************************************
        mapped = (PADDR == uart_pkg::CTL_OFS) || (PADDR == uart_pkg::BUF_OFS) ||
                 (PADDR == uart_pkg::PWR_OFS) || (PADDR == uart_pkg::ADDR_OFS) ||
                 (PADDR == uart_pkg::MASK_OFS) || (PADDR == uart_pkg::BAUD_OFS) ||
                 (PADDR == uart_pkg::ISTAT_OFS) || (PADDR == uart_pkg::IMASK_OFS);
        rd = 32'h0000_0000;
        case (PADDR)
            uart_pkg::CTL_OFS:   rd[uart_pkg::CTL_W-1:0] = q.ctl;
            // [RULE1] read returns receive register
            uart_pkg::BUF_OFS:   rd[7:0] = q.rx_buf;
            uart_pkg::PWR_OFS:   rd[uart_pkg::PWR_FRAME_CHECK] = q.fc_sel;
            uart_pkg::ADDR_OFS:  rd[7:0] = q.own_addr;
            uart_pkg::MASK_OFS:  rd[7:0] = q.mask;
            uart_pkg::BAUD_OFS:  rd[15:0] = q.baud;
            uart_pkg::ISTAT_OFS: rd[uart_pkg::IRQ_W-1:0] = q.istat;
            uart_pkg::IMASK_OFS: rd[uart_pkg::IRQ_W-1:0] = q.imask;
            default:             rd = 32'h0000_0000;
        endcase
        n.pready = PSEL && PENABLE && !q.pready;
        if (PSEL && PENABLE && !q.pready) begin
            n.prdata  = rd;
            n.pslverr = !mapped;
        end else begin
            n.prdata  = 32'h0000_0000;
            n.pslverr = 1'b0;
        end
        commit = PSEL && PENABLE && q.pready && mapped;
        if (commit && !PWRITE && PADDR == uart_pkg::ISTAT_OFS) begin
            n.istat = '0;
        end
        if (commit && PWRITE) begin
            case (PADDR)
                uart_pkg::CTL_OFS:   n.ctl = PWDATA[uart_pkg::CTL_W-1:0];
                uart_pkg::PWR_OFS:   n.fc_sel = PWDATA[uart_pkg::PWR_FRAME_CHECK];
                uart_pkg::ADDR_OFS:  n.own_addr = PWDATA[7:0];
                uart_pkg::MASK_OFS:  n.mask = PWDATA[7:0];
                uart_pkg::BAUD_OFS:  n.baud = PWDATA[15:0];
                uart_pkg::IMASK_OFS: n.imask = PWDATA[uart_pkg::IRQ_W-1:0];
                default:             n.baud = q.baud;
            endcase
        end

        // **************************************************
        // Transmitter and mode 0 shift engine
        // **************************************************
        if (q.tx_st == uart_pkg::TX_RUN) begin
            n.tx_cnt = q.tx_cnt + 16'h0001;
            // Mode 0 samples at the rising shift clock
            if (q.m0_rx && q.tx_cnt == half_len - 16'h0001) begin
                n.rx_sh = {RXD_I, q.rx_sh[8:1]};
            end
            if (q.tx_cnt == bit_len - 16'h0001) begin
                n.tx_cnt  = 16'h0000;
                n.tx_sh   = {1'b1, q.tx_sh[10:1]};
                n.tx_bits = q.tx_bits - 4'h1;
                if (q.tx_bits == 4'h1) begin
                    n.tx_st = uart_pkg::TX_IDLE;
                    if (q.m0_rx) begin
                        n.rx_buf                     = n.rx_sh[8:1];
                        n.ctl[uart_pkg::CTL_RX_DONE] = 1'b1;
                        ev[uart_pkg::IRQ_RX]         = 1'b1;
                    end else begin
                        ev[uart_pkg::IRQ_TX] = 1'b1;
                    end
                end
            end
        end else if (mode == uart_pkg::MODE_SHIFT && q.ctl[uart_pkg::CTL_RX_ALLOW] &&
                     !q.ctl[uart_pkg::CTL_RX_DONE]) begin
            // [RULE4] mode 0 receive start
            n.tx_st   = uart_pkg::TX_RUN;
            n.m0_rx   = 1'b1;
            n.tx_cnt  = 16'h0000;
            n.tx_bits = 4'h8;
            n.tx_sh   = 11'h7FF;
        end
        // [RULE3] buffer write starts transmit
        if (commit && PWRITE && PADDR == uart_pkg::BUF_OFS) begin
            n.tx_st  = uart_pkg::TX_RUN;
            n.m0_rx  = 1'b0;
            n.tx_cnt = 16'h0000;
            unique case (mode)
                uart_pkg::MODE_SHIFT: begin
                    n.tx_sh   = {3'b111, PWDATA[7:0]};
                    n.tx_bits = 4'h8;
                end
                uart_pkg::MODE_8VAR: begin
                    n.tx_sh   = {2'b11, PWDATA[7:0], 1'b0};
                    n.tx_bits = 4'hA;
                end
                default: begin
                    // [RULE12] ninth bit marks address or data
                    n.tx_sh   = {1'b1, q.ctl[uart_pkg::CTL_TX_B9], PWDATA[7:0], 1'b0};
                    n.tx_bits = 4'hB;
                end
            endcase
        end
        if (ev[uart_pkg::IRQ_TX]) begin
            n.ctl[uart_pkg::CTL_TX_DONE] = 1'b1;
        end

        // **************************************************
        // Asynchronous receiver
        // **************************************************
        n.rxd_prev = RXD_I;
        unique case (q.rx_st)
            uart_pkg::RX_IDLE: begin
                // [RULE5] start bit only while allowed
                if (mode != uart_pkg::MODE_SHIFT && q.ctl[uart_pkg::CTL_RX_ALLOW] &&
                    q.rxd_prev && !RXD_I) begin
                    n.rx_st  = uart_pkg::RX_START;
                    n.rx_cnt = 16'h0000;
                end
            end
            uart_pkg::RX_START: begin
                n.rx_cnt = q.rx_cnt + 16'h0001;
                if (q.rx_cnt == half_len - 16'h0001) begin
                    n.rx_cnt  = 16'h0000;
                    n.rx_bits = 4'h0;
                    n.rx_st   = RXD_I ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                end
            end
            uart_pkg::RX_DATA: begin
                n.rx_cnt = q.rx_cnt + 16'h0001;
                if (q.rx_cnt == bit_len - 16'h0001) begin
                    n.rx_cnt  = 16'h0000;
                    n.rx_sh   = {RXD_I, q.rx_sh[8:1]};
                    n.rx_bits = q.rx_bits + 4'h1;
                    if (q.rx_bits == ((mode == uart_pkg::MODE_8VAR) ? 4'h7 : 4'h8)) begin
                        n.rx_st = uart_pkg::RX_STOP;
                        if (early) begin
                            dec_now  = 1'b1;
                            dec_b9   = (mode == uart_pkg::MODE_8VAR) ? 1'b1 : n.rx_sh[8];
                            dec_data = (mode == uart_pkg::MODE_8VAR) ? n.rx_sh[8:1] : n.rx_sh[7:0];
                        end
                    end
                end
            end
            uart_pkg::RX_STOP: begin
                n.rx_cnt = q.rx_cnt + 16'h0001;
                if (q.rx_cnt == bit_len - 16'h0001) begin
                    n.rx_st = uart_pkg::RX_IDLE;
                    // [RULE6] [RULE7] stop-bit check
                    if (q.fc_sel && !RXD_I) begin
                        n.ctl[uart_pkg::CTL_FRAME_FAULT] = 1'b1;
                        ev[uart_pkg::IRQ_FAULT]          = 1'b1;
                    end
                    if (!early) begin
                        dec_now = 1'b1;
                        // [RULE13] stop bit as ninth bit
                        dec_b9   = (mode == uart_pkg::MODE_8VAR) ? RXD_I : q.rx_sh[8];
                        dec_data = (mode == uart_pkg::MODE_8VAR) ? q.rx_sh[8:1] : q.rx_sh[7:0];
                    end
                end
            end
        endcase

        // **************************************************
        // Address recognition and acceptance
        // **************************************************
        // [RULE15] given address compare
        bcast = q.own_addr | q.mask;
        // [RULE16] [RULE17] broadcast compare
        match = (((dec_data ^ q.own_addr) & q.mask) == 8'h00) || ((dec_data & bcast) == bcast);
        // [RULE10] [RULE11] [RULE12] frame acceptance
        if (dec_now && !q.ctl[uart_pkg::CTL_RX_DONE] && (!filt || (dec_b9 && match))) begin
            n.rx_buf                     = dec_data;
            n.ctl[uart_pkg::CTL_RX_B9]   = dec_b9;
            n.ctl[uart_pkg::CTL_RX_DONE] = 1'b1;
            ev[uart_pkg::IRQ_RX]         = 1'b1;
        end

        // **************************************************
        // Pins and interrupt
        // **************************************************
        if (mode == uart_pkg::MODE_SHIFT) begin
            n.txd      = !(n.tx_st == uart_pkg::TX_RUN && n.tx_cnt < half_len);
            n.rxd_o    = n.tx_sh[0];
            n.rxd_oe_n = !(n.tx_st == uart_pkg::TX_RUN && !n.m0_rx);
        end else begin
            n.txd      = (n.tx_st == uart_pkg::TX_RUN) ? n.tx_sh[0] : 1'b1;
            n.rxd_o    = 1'b1;
            n.rxd_oe_n = 1'b1;
        end
        // [RULE8] flags cleared only by software
        n.istat = n.istat | ev;
        n.irq   = |(n.istat & n.imask);
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            q          <= '0;
            q.ctl      <= uart_pkg::CTL_RST;
            q.own_addr <= uart_pkg::ADDR_RST;
            q.mask     <= uart_pkg::MASK_RST;
            q.baud     <= uart_pkg::BAUD_RST;
            q.tx_st    <= uart_pkg::TX_IDLE;
            q.tx_sh    <= 11'h7FF;
            q.rx_st    <= uart_pkg::RX_IDLE;
            q.rxd_prev <= 1'b1;
            q.txd      <= 1'b1;
            q.rxd_o    <= 1'b1;
            q.rxd_oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign PRDATA   = q.prdata;
    assign PREADY   = q.pready;
    assign PSLVERR  = q.pslverr;
    assign RXD_O    = q.rxd_o;
    assign RXD_OE_N = q.rxd_oe_n;
    assign TXD      = q.txd;
    assign IRQ      = q.irq;

endmodule // uart_frame_check_addr_match

`default_nettype wire

// ===== verif/uart_frame_check_addr_match_assertions.sv
// Port assertions for the serial port
`timescale 1ns/1ps
`default_nettype none
module uart_frame_check_addr_match_checker (
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        RXD_O,
    input wire logic        RXD_OE_N,
    input wire logic        TXD,
    input wire logic        IRQ
);
    // ****
    // Bus and line relations
    // ****
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    logic acc;
    assign acc = PSEL && PENABLE && PREADY;
    property p_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_wait: assert property (p_wait) else $error("ready missing after wait state");
    property p_pulse; PREADY |=> !PREADY; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; PSLVERR |-> PREADY && PRDATA == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("error without ready or with data");
    property p_ctl; acc && !PWRITE && PADDR == uart_pkg::CTL_OFS |-> PRDATA[31:9] == 23'h00_0000; endproperty
    a_ctl: assert property (p_ctl) else $error("control read has upper bits");
    property p_txgo; acc && PWRITE && PADDR == uart_pkg::BUF_OFS |-> ##[1:2] !TXD; endproperty
    a_txgo: assert property (p_txgo) else $error("buffer write did not start transmit");
    property p_hold; $changed(TXD) |=> $stable(TXD); endproperty
    a_hold: assert property (p_hold) else $error("transmit line glitch");
    property p_narrow;
        acc && !PWRITE && (PADDR == uart_pkg::ADDR_OFS || PADDR == uart_pkg::MASK_OFS) |-> PRDATA[31:8] == 24'h00_0000;
    endproperty
    a_narrow: assert property (p_narrow) else $error("address register read too wide");
    property p_irq; acc && !PWRITE && PADDR == uart_pkg::ISTAT_OFS |-> ##2 !IRQ; endproperty
    a_irq: assert property (p_irq) else $error("interrupt stays after status read");
    property p_oe; RXD_OE_N |-> RXD_O; endproperty
    a_oe: assert property (p_oe) else $error("data out not idle while released");
    c_tx: cover property (acc && PWRITE && PADDR == uart_pkg::BUF_OFS);
    c_err: cover property (PSLVERR);
    c_irq: cover property ($rose(IRQ));
endmodule // uart_frame_check_addr_match_checker
bind uart_frame_check_addr_match uart_frame_check_addr_match_checker checker_inst (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD_O(RXD_O), .RXD_OE_N(RXD_OE_N), .TXD(TXD), .IRQ(IRQ)
);
`default_nettype wire

// ===== verif/serial_peer_model.sv
// Remote serial node: sends frames, decodes transmit line, feeds shift data
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk,
    output var  logic line_out,
    input  wire logic line_in
);
    logic [7:0] tx_byte;
    int         tx_cnt = 0;
    logic [7:0] m0_byte = 8'h00;
    logic       m0_on = 1'h0;
    logic [2:0] m0_idx = 3'h0;
    initial begin
        line_out = 1'h1;
    end
    task automatic send(input logic [7:0] d, input logic b9, input logic nine, input logic st, input int bl);
        logic [10:0] f;
        f = nine ? {st, b9, d, 1'h0} : {1'h1, st, d, 1'h0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            line_out <= f[i];
            repeat (bl) @(posedge clk);
        end
        line_out <= 1'h1;
        repeat (2 * bl) @(posedge clk);
    endtask
    // Shift data on clock fall, else decode
    always @(negedge line_in) begin
        if (m0_on) begin
            line_out <= m0_byte[m0_idx];
            m0_idx <= m0_idx + 3'h1;
        end else begin
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                tx_byte[i] = line_in;
            end
            tx_cnt++;
        end
    end
endmodule // serial_peer_model
`default_nettype wire

// ===== verif/uart_frame_check_addr_match_bench.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module uart_frame_check_addr_match_bench;
    localparam int BL = 16;
    logic        SYS_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        RXD_I, RXD_O, RXD_OE_N, TXD, IRQ, peer_line, rerr;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rdat;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          k;
    assign RXD_I = RXD_OE_N ? peer_line : RXD_O;
    uart_frame_check_addr_match uart_frame_check_addr_match_inst (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD_I(RXD_I),
        .RXD_O(RXD_O), .RXD_OE_N(RXD_OE_N), .TXD(TXD), .IRQ(IRQ));
    serial_peer_model #(.BIT_CYC(BL)) serial_peer_model_inst (.clk(SYS_CLK), .line_out(peer_line), .line_in(TXD));
    // ****
    // Bus access and checks
    // ****
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        PSEL <= 1'h1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {16'h0000, d};
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'h1 && n < 20);
        chk("ready", 32'h0000_0001, 32'(n < 20));
        if (n >= 20) begin
            close_out();
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge SYS_CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] e);
        apb(1'h0, a, 16'h0000);
        chk(what, {16'h0000, e}, rdat);
    endtask
    task automatic rx(input logic [1:0] m, input logic f, input logic [7:0] d, input logic b9,
                      input logic st, input logic ed, input logic fi, input logic fe);
        wr(uart_pkg::CTL_OFS, {7'h00, fi, m, f, 5'h10});
        serial_peer_model_inst.send(d, b9, m[1], st, m == 2'b10 ? int'(uart_pkg::M2_BIT_CYC) : BL);
        apb(1'h0, uart_pkg::CTL_OFS, 16'h0000);
        chk("rx_done", 32'(ed), 32'(rdat[uart_pkg::CTL_RX_DONE]));
        chk("frame_fault", 32'(fe), 32'(rdat[uart_pkg::CTL_FRAME_FAULT]));
        if (ed) begin
            rdchk("rx_byte", uart_pkg::BUF_OFS, {8'h00, d});
        end
    endtask
    task automatic early(input logic c, input logic e);
        wr(uart_pkg::PWR_OFS, {9'h000, c, 6'h00});
        wr(uart_pkg::CTL_OFS, 16'h0050);
        fork
            serial_peer_model_inst.send(8'h5A, 1'h0, 1'h0, 1'h1, BL);
            begin
                repeat (9 * BL) @(posedge SYS_CLK);
                apb(1'h0, uart_pkg::CTL_OFS, 16'h0000);
                chk("early_done", 32'(e), 32'(rdat[uart_pkg::CTL_RX_DONE]));
            end
        join
    endtask
    initial begin
        SYS_CLK = 1'h0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    // ****
    // Scenarios
    // ****
    initial begin
        RESET = 1'h1;
        PSEL = 1'h0;
        PENABLE = 1'h0;
        PWRITE = 1'h0;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        repeat (8) @(posedge SYS_CLK);
        RESET <= 1'h0;
        @(posedge SYS_CLK);
        rdchk("ctl", uart_pkg::CTL_OFS, 16'h0000);
        rdchk("own_address", uart_pkg::ADDR_OFS, 16'h0000);
        rdchk("address_mask", uart_pkg::MASK_OFS, 16'h0000);
        rdchk("baud", uart_pkg::BAUD_OFS, uart_pkg::BAUD_RST);
        rdchk("unmapped", 8'h20, 16'h0000);
        chk("slverr", 32'h0000_0001, 32'(rerr));
        wr(uart_pkg::BAUD_OFS, 16'(BL));
        wr(uart_pkg::IMASK_OFS, 16'h0002);
        rx(2'b11, 1'h1, 8'h37, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
        chk("irq_set", 32'h0000_0001, 32'(IRQ));
        rdchk("istat", uart_pkg::ISTAT_OFS, 16'h0002);
        @(posedge SYS_CLK);
        chk("irq_clear", 32'h0000_0000, 32'(IRQ));
        wr(uart_pkg::ADDR_OFS, 16'h00F1);
        wr(uart_pkg::MASK_OFS, 16'h00FA);
        rdchk("own_address", uart_pkg::ADDR_OFS, 16'h00F1);
        rdchk("address_mask", uart_pkg::MASK_OFS, 16'h00FA);
        rx(2'b11, 1'h1, 8'hF0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
        rx(2'b11, 1'h1, 8'hF2, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        rx(2'b11, 1'h1, 8'hFB, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
        rx(2'b11, 1'h1, 8'hF0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
        rx(2'b11, 1'h1, 8'h7F, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
        rx(2'b11, 1'h0, 8'h55, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
        rx(2'b10, 1'h1, 8'hF5, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
        rx(2'b01, 1'h1, 8'hF4, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
        rx(2'b01, 1'h1, 8'hF4, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        rx(2'b01, 1'h0, 8'hA5, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
        wr(uart_pkg::PWR_OFS, 16'h0040);
        rx(2'b01, 1'h0, 8'hA5, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
        rx(2'b01, 1'h0, 8'h3C, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
        rx(2'b10, 1'h0, 8'h96, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
        early(1'h1, 1'h0);
        early(1'h0, 1'h1);
        wr(uart_pkg::IMASK_OFS, 16'h0000);
        rdchk("istat_fault", uart_pkg::ISTAT_OFS, 16'h0006);
        wr(uart_pkg::CTL_OFS, 16'h0050);
        k = serial_peer_model_inst.tx_cnt;
        fork
            wr(uart_pkg::BUF_OFS, 16'h00A5);
            serial_peer_model_inst.send(8'h3C, 1'h0, 1'h0, 1'h1, BL);
        join
        chk("tx_count", 32'(k + 1), 32'(serial_peer_model_inst.tx_cnt));
        chk("tx_byte", 32'h0000_00A5, 32'(serial_peer_model_inst.tx_byte));
        rdchk("rx_byte", uart_pkg::BUF_OFS, 16'h003C);
        chk("irq_masked", 32'h0000_0000, 32'(IRQ));
        rdchk("istat", uart_pkg::ISTAT_OFS, 16'h0003);
        serial_peer_model_inst.m0_byte = 8'h96;
        serial_peer_model_inst.m0_idx = 3'h0;
        serial_peer_model_inst.m0_on = 1'h1;
        wr(uart_pkg::CTL_OFS, 16'h0030);
        k = 0;
        do begin
            apb(1'h0, uart_pkg::CTL_OFS, 16'h0000);
            k++;
        end while (rdat[uart_pkg::CTL_RX_DONE] !== 1'h1 && k < 100);
        chk("mode0_done", 32'h0000_0001, 32'(rdat[uart_pkg::CTL_RX_DONE]));
        rdchk("mode0_byte", uart_pkg::BUF_OFS, 16'h0096);
        wr(uart_pkg::CTL_OFS, 16'h0000);
        wr(uart_pkg::BUF_OFS, 16'h00C3);
        rdat = 32'h0000_0000;
        for (int i = 0; i < 96; i++) begin
            @(posedge SYS_CLK);
            if (i % 12 == 5) begin
                rdat[i / 12] = RXD_O;
                rdat[8 + i / 12] = RXD_OE_N;
            end
        end
        chk("mode0_tx", 32'h0000_00C3, rdat);
        serial_peer_model_inst.m0_on = 1'h0;
        close_out();
    end
endmodule // uart_frame_check_addr_match_bench
`default_nettype wire
